// file: logic/ugm_pkg.sv
// constants and types of the usb general and endpoint memory block
//
// Functional notes
// (R1) firmware allocates endpoints in ascending order
// (R2) allocate inserts buffer, next endpoint slides up
// (R3) enable clear keeps layout; free slides next down
// (R4) endpoint 0 buffer lost only on own deactivation
// (R5) reactivation with same parameters moves nothing
// (R6) config valid set despite buffer overlap
// (R7) suspend idles pad; line activity wakes it
// (R8) detach holds pad idle until cleared
// (R9) voltage status follows session valid input
// (R10) voltage change flag sticky; gated interrupt enable
// (R11) no bus connection without bus voltage
// (R12) pull-up only when attached and voltage present
// (R13) regulator register bit 0 enables regulator
// (R14) controller enable clear acts as reset
// (R15) freeze bit gates controller clocks
// (R16) voltage pad enable works while disabled
// (R17) status: bit1 reads one, bit0 voltage
// (R18) reset: frozen, detached, banks cleared, pull-up off
// (R19) endpoint reset clears banks, status, machine
// (R20) endpoint reset keeps toggle, config, enable
// (R21) bus reset disables endpoints except endpoint 0
// (R22) bus reset optionally resets cpu, stays attached
// (R23) ram 832 bytes; per endpoint size limits
// (R24) while frozen only wakeup and voltage events
// (R25) wakeup and suspend flags clear each other
package ugm_pkg;

  localparam int unsigned CLK_MHZ     = 250;
  localparam int unsigned BUS_RST_NS  = 2500;
  localparam int unsigned BUS_RST_CYC = (BUS_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned NUM_EP      = 7;
  localparam int unsigned RAM_BYTES   = 832;
  localparam int unsigned UNIT_BYTES  = 8;
  localparam int unsigned BASE_W      = 9;
  localparam logic [2:0]  MAX_SZ_EP1  = 3'h5;
  localparam logic [2:0]  MAX_SZ_EPN  = 3'h3;

  // byte addresses on the register bus
  localparam logic [7:0] A_PADREG = 8'h00;
  localparam logic [7:0] A_GENCTL = 8'h04;
  localparam logic [7:0] A_GENSTA = 8'h08;
  localparam logic [7:0] A_GENINT = 8'h0C;
  localparam logic [7:0] A_DEVCTL = 8'h10;
  localparam logic [7:0] A_DEVINT = 8'h14;
  localparam logic [7:0] A_EPSEL  = 8'h18;
  localparam logic [7:0] A_EPCFG  = 8'h1C;
  localparam logic [7:0] A_EPRST  = 8'h20;
  localparam logic [7:0] A_EPBASE = 8'h24;

  // field positions
  localparam int unsigned PAD_REG_EN = 0;
  localparam int unsigned CTL_EN     = 7;
  localparam int unsigned CTL_FRZ    = 5;
  localparam int unsigned CTL_VPAD   = 4;
  localparam int unsigned CTL_VBIE   = 0;
  localparam int unsigned STA_LEGACY = 1;
  localparam int unsigned STA_VBUS   = 0;
  localparam int unsigned INT_VBUS   = 0;
  localparam int unsigned DEV_DETACH = 0;
  localparam int unsigned DEV_CPURST = 1;
  localparam int unsigned DI_SUSP    = 0;
  localparam int unsigned DI_WAKE    = 1;
  localparam int unsigned EC_EN      = 0;
  localparam int unsigned EC_BUFFER_ALLOCATE   = 1;
  localparam int unsigned EC_SZ      = 2;
  localparam int unsigned EC_BK      = 5;
  localparam int unsigned EC_TOG     = 6;
  localparam int unsigned EC_OK      = 7;

  // values after reset of the bits that do not reset to zero
  localparam logic FRZ_RST    = 1'b1;
  localparam logic DETACH_RST = 1'b1;

  typedef struct packed {
    logic       config_valid;
    logic       bank2;
    logic [2:0] size;
    logic       buffer_allocate;
    logic       en;
  } ugm_ep_t;

  typedef struct packed {
    logic padIdle;
    logic pullupOn;
    logic xcvrEn;
    logic coreClkEn;
    logic padRegEn;
    logic vpadEn;
  } ugm_pad_t;

  typedef struct packed {
    logic                               padReg;
    logic                               ctlEn;
    logic                               frz;
    logic                               vpadEn;
    logic                               vbusIe;
    logic                               vbus;
    logic                               vbusFlag;
    logic                               detach;
    logic                               cpuRstEn;
    logic                               suspFlag;
    logic                               wakeFlag;
    logic [2:0]                         epSel;
    ugm_ep_t [NUM_EP-1:0]               ep;
    logic [NUM_EP-1:0][BASE_W-1:0]      base;
    logic [NUM_EP-1:0]                  flush;
    logic [NUM_EP-1:0]                  epRst;
    logic [NUM_EP-1:0]                  togRst;
    logic                               cpuRst;
    logic [7:0]                         rdata;
    logic                               err;
  } ugm_state_t;

endpackage : ugm_pkg

// file: logic/ugm_se0_timer.sv
// bus reset detector: qualified single-ended-zero duration
`timescale 1ns/10ps
`default_nettype none
module ugm_se0_timer #(
  parameter int unsigned COUNT = ugm_pkg::BUS_RST_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic se0,
  output logic      fire
);

  if (COUNT < 2 || COUNT > 65535)
  begin : g_bad_count
    $error("ugm_se0_timer: COUNT out of range");
  end

  typedef struct packed {
    logic [15:0] cnt;
    logic        done;
    logic        fire;
  } ugm_tmr_t;

  ugm_tmr_t t_reg;
  ugm_tmr_t t_next;

  localparam logic [15:0] LAST = 16'(COUNT - 1);

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    t_next      = t_reg;
    t_next.fire = 1'b0;
    // frozen clock clears the count, line must stay low without a break
    if (!enable || !se0)
    begin
      t_next.cnt  = 16'h0000;
      t_next.done = 1'b0;
    end
    else if (!t_reg.done)
    begin
      // (R21) fire once per reset
      if (t_reg.cnt == LAST)
      begin
        t_next.done = 1'b1;
        t_next.fire = 1'b1;
      end
      else
        t_next.cnt = t_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      t_reg <= '0;
    else
      t_reg <= t_next;
  end

  assign fire = t_reg.fire;

endmodule : ugm_se0_timer
`default_nettype wire

// file: logic/ugm_general.sv
// usb general control, pad control and endpoint memory allocator
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ugm_general (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        sessionValid,
  input  wire logic                        se0Line,
  input  wire logic                        lineActivity,
  input  wire logic                        suspendDet,
  output ugm_pkg::ugm_pad_t                pad,
  output logic                             vbusIrq,
  output logic [ugm_pkg::NUM_EP-1:0]       epEnable,
  output logic [ugm_pkg::NUM_EP-1:0]       epResetPulse,
  output logic [ugm_pkg::NUM_EP-1:0]       bankFlush,
  output logic [ugm_pkg::NUM_EP-1:0]       toggleReset,
  output logic                             cpuReset
);

  localparam logic [2:0] LAST_EP = 3'(ugm_pkg::NUM_EP - 1);

  ugm_pkg::ugm_state_t s_reg;
  ugm_pkg::ugm_state_t s_next;

  logic       busRst;
  logic       run;
  logic       wrEn;
  logic [7:0] wd;

  ////////////////////////////////////////////////////////////////////////
  // buffer length of one endpoint in 8-byte units, zero when free
  function automatic logic [ugm_pkg::BASE_W-1:0] lenU(
    input ugm_pkg::ugm_ep_t e
  );
    logic [ugm_pkg::BASE_W-1:0] one;
    one = 9'h001 << e.size;
    if (!e.buffer_allocate)
      lenU = 9'h000;
    else if (e.bank2)
      lenU = one << 1;
    else
      lenU = one;
  endfunction : lenU

  // size limit and single bank for endpoint 0; overlap is never checked
  // (R23) per endpoint size limits
  function automatic logic fits(
    input logic [2:0]       k,
    input ugm_pkg::ugm_ep_t e
  );
    logic [2:0] lim;
    lim = (k == 3'h1) ? ugm_pkg::MAX_SZ_EP1 : ugm_pkg::MAX_SZ_EPN;
    fits = (e.size <= lim) && !(k == 3'h0 && e.bank2);
  endfunction : fits

  ////////////////////////////////////////////////////////////////////////
  // (R15) bus reset timing is cleared while frozen
  ugm_se0_timer #(
    .COUNT (ugm_pkg::BUS_RST_CYC)
  ) u_se0 (
    .clk    (clk),
    .rst    (rst),
    .enable (run),
    .se0    (se0Line),
    .fire   (busRst)
  );

  assign run  = s_reg.ctlEn & ~s_reg.frz;
  assign wrEn = psel & penable & pwrite;
  assign wd   = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [2:0]                 k;
    logic [2:0]                 km;
    logic [2:0]                 kp;
    ugm_pkg::ugm_ep_t           e;
    ugm_pkg::ugm_ep_t           old;
    logic [ugm_pkg::BASE_W-1:0] nb;
    logic [ugm_pkg::BASE_W-1:0] nx;
    logic [7:0]                 rd;
    logic                       mapped;
    k      = s_reg.epSel;
    km     = (k == 3'h0) ? 3'h0 : k - 3'h1;
    kp     = (k == LAST_EP) ? LAST_EP : k + 3'h1;
    old    = s_reg.ep[k];
    e      = old;
    nb     = '0;
    nx     = '0;
    rd     = 8'h00;
    mapped = 1'b1;

    s_next        = s_reg;
    s_next.flush  = '0;
    s_next.epRst  = '0;
    s_next.togRst = '0;
    s_next.cpuRst = 1'b0;

    // register writes, taken in the access phase
    if (wrEn)
    begin
      case (paddr)
        ugm_pkg::A_PADREG:
          // (R13) only the enable bit is stored
          s_next.padReg = wd[ugm_pkg::PAD_REG_EN];
        ugm_pkg::A_GENCTL:
        begin
          s_next.ctlEn  = wd[ugm_pkg::CTL_EN];
          s_next.frz    = wd[ugm_pkg::CTL_FRZ];
          // (R16) writable whatever the controller enable
          s_next.vpadEn = wd[ugm_pkg::CTL_VPAD];
          s_next.vbusIe = wd[ugm_pkg::CTL_VBIE];
        end
        ugm_pkg::A_GENINT:
          if (!wd[ugm_pkg::INT_VBUS])
            s_next.vbusFlag = 1'b0;
        ugm_pkg::A_DEVCTL:
        begin
          s_next.detach   = wd[ugm_pkg::DEV_DETACH];
          s_next.cpuRstEn = wd[ugm_pkg::DEV_CPURST];
        end
        ugm_pkg::A_DEVINT:
        begin
          if (!wd[ugm_pkg::DI_SUSP])
            s_next.suspFlag = 1'b0;
          if (!wd[ugm_pkg::DI_WAKE])
            s_next.wakeFlag = 1'b0;
        end
        ugm_pkg::A_EPSEL:
          if (wd[2:0] <= LAST_EP)
            s_next.epSel = wd[2:0];
        ugm_pkg::A_EPCFG:
        begin
          e.en    = wd[ugm_pkg::EC_EN];
          e.buffer_allocate = wd[ugm_pkg::EC_BUFFER_ALLOCATE];
          e.size  = wd[ugm_pkg::EC_SZ +: 3];
          e.bank2 = wd[ugm_pkg::EC_BK];
          // (R6) valid even when areas overlap
          e.config_valid = e.buffer_allocate & fits(k, e);
          s_next.ep[k] = e;
          s_next.togRst[k] = wd[ugm_pkg::EC_TOG];
          // (R4) endpoint 0 loses data on its own deactivation
          if (k == 3'h0 && old.en && !e.en)
            s_next.flush[0] = 1'b1;
          if (e.buffer_allocate && !old.buffer_allocate)
          begin
            // (R1) lower neighbour already placed
            // (R2) insert above the lower neighbour
            nb = (k == 3'h0) ? '0 : s_reg.base[km] + lenU(s_reg.ep[km]);
            s_next.base[k] = nb;
            nx = nb + lenU(e);
            // (R5) unchanged layout keeps the upper data
            if (k != LAST_EP && nx != s_reg.base[kp])
            begin
              s_next.base[kp]  = nx;
              s_next.flush[kp] = 1'b1;
            end
          end
          else if (!e.buffer_allocate && old.buffer_allocate)
          begin
            // (R3) free and pull the next one down
            s_next.flush[k] = 1'b1;
            if (k != LAST_EP && s_reg.base[kp] != s_reg.base[k])
            begin
              s_next.base[kp]  = s_reg.base[k];
              s_next.flush[kp] = 1'b1;
            end
          end
        end
        ugm_pkg::A_EPRST:
        begin
          // (R19) banks and status back to reset
          s_next.epRst = wd[ugm_pkg::NUM_EP-1:0];
          s_next.flush = wd[ugm_pkg::NUM_EP-1:0];
          // (R20) configuration, enable and toggle kept
        end
        default:
          ;
      endcase
    end

    // hardware events come after writes so that a set beats a clear
    // (R9) status follows the session valid input
    s_next.vbus = sessionValid;
    // (R10) either edge sets the sticky change flag
    if (sessionValid != s_reg.vbus)
      s_next.vbusFlag = 1'b1;

    // (R24) suspend is a clocked event, lost while frozen
    if (suspendDet && run)
    begin
      // (R25) suspend clears wakeup
      s_next.suspFlag = 1'b1;
      s_next.wakeFlag = 1'b0;
    end
    // (R7) resume detection still runs while frozen
    if (lineActivity && s_reg.ctlEn)
    begin
      // (R25) wakeup clears suspend
      s_next.wakeFlag = 1'b1;
      s_next.suspFlag = 1'b0;
    end

    // (R21) bus reset drops all but the control endpoint
    if (busRst)
    begin
      for (int i = 1; i < ugm_pkg::NUM_EP; i++)
        s_next.ep[i].en = 1'b0;
      // (R22) cpu reset without touching the controller
      s_next.cpuRst = s_reg.cpuRstEn;
    end

    // (R14) a disabled controller is held in its reset state
    if (!s_reg.ctlEn)
    begin
      s_next.detach   = ugm_pkg::DETACH_RST;
      s_next.cpuRstEn = 1'b0;
      s_next.suspFlag = 1'b0;
      s_next.wakeFlag = 1'b0;
      s_next.epSel    = 3'h0;
      s_next.ep       = '0;
      s_next.base     = '0;
      s_next.epRst    = '0;
      s_next.togRst   = '0;
      s_next.cpuRst   = 1'b0;
      s_next.flush    = {ugm_pkg::NUM_EP{s_reg.ctlEn == 1'b0}};
    end

    // read data captured in the setup phase, shown in the access phase
    case (paddr)
      ugm_pkg::A_PADREG:
        rd[ugm_pkg::PAD_REG_EN] = s_reg.padReg;
      ugm_pkg::A_GENCTL:
      begin
        rd[ugm_pkg::CTL_EN]   = s_reg.ctlEn;
        rd[ugm_pkg::CTL_FRZ]  = s_reg.frz;
        rd[ugm_pkg::CTL_VPAD] = s_reg.vpadEn;
        rd[ugm_pkg::CTL_VBIE] = s_reg.vbusIe;
      end
      ugm_pkg::A_GENSTA:
      begin
        // (R17) legacy bit fixed at one
        rd[ugm_pkg::STA_LEGACY] = 1'b1;
        rd[ugm_pkg::STA_VBUS]   = s_reg.vbus;
      end
      ugm_pkg::A_GENINT:
        rd[ugm_pkg::INT_VBUS] = s_reg.vbusFlag;
      ugm_pkg::A_DEVCTL:
      begin
        rd[ugm_pkg::DEV_DETACH] = s_reg.detach;
        rd[ugm_pkg::DEV_CPURST] = s_reg.cpuRstEn;
      end
      ugm_pkg::A_DEVINT:
      begin
        rd[ugm_pkg::DI_SUSP] = s_reg.suspFlag;
        rd[ugm_pkg::DI_WAKE] = s_reg.wakeFlag;
      end
      ugm_pkg::A_EPSEL:
        rd[2:0] = s_reg.epSel;
      ugm_pkg::A_EPCFG:
      begin
        rd[ugm_pkg::EC_EN]       = old.en;
        rd[ugm_pkg::EC_BUFFER_ALLOCATE]    = old.buffer_allocate;
        rd[ugm_pkg::EC_SZ +: 3]  = old.size;
        rd[ugm_pkg::EC_BK]       = old.bank2;
        rd[ugm_pkg::EC_OK]       = old.config_valid;
      end
      ugm_pkg::A_EPRST:
        rd = 8'h00;
      ugm_pkg::A_EPBASE:
        // base in 8-byte units; 832 bytes fit in 104 units
        rd = s_reg.base[k][7:0];
      default:
        mapped = 1'b0;
    endcase
    if (psel && !penable)
    begin
      s_next.rdata = rd;
      s_next.err   = ~mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // (R18) frozen, detached, banks empty, pull-up off
      s_reg        <= '0;
      s_reg.frz    <= ugm_pkg::FRZ_RST;
      s_reg.detach <= ugm_pkg::DETACH_RST;
    end
    else
      s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // zero wait states; decode and data settle in the setup phase
  assign pready  = psel & penable;
  assign pslverr = psel & penable & s_reg.err;
  assign prdata  = {24'h000000, s_reg.rdata};

  // one process drives the whole pad struct
  always_comb
  begin
    // (R15) clock gate, also off while disabled
    pad.coreClkEn = s_reg.ctlEn & ~s_reg.frz;
    // (R14) transceiver follows the controller enable
    pad.xcvrEn    = s_reg.ctlEn;
    // (R8) detach or suspend idles the pad
    pad.padIdle   = ~s_reg.ctlEn | s_reg.detach | s_reg.suspFlag;
    // (R11) no voltage, no connection
    // (R12) attach needs detach clear and voltage present
    pad.pullupOn  = s_reg.ctlEn & ~s_reg.detach & s_reg.vbus;
    pad.padRegEn  = s_reg.padReg;
    pad.vpadEn    = s_reg.vpadEn;
  end

  // (R10) interrupt gated by its enable, also while frozen
  assign vbusIrq = s_reg.vbusFlag & s_reg.vbusIe;

  always_comb
  begin
    for (int i = 0; i < ugm_pkg::NUM_EP; i++)
      epEnable[i] = s_reg.ep[i].en;
  end

  assign epResetPulse = s_reg.epRst;
  assign bankFlush    = s_reg.flush;
  assign toggleReset  = s_reg.togRst;
  assign cpuReset     = s_reg.cpuRst;

endmodule : ugm_general
`default_nettype wire

// file: dv/ugm_general_asserts.sv
// port checker for the usb general control block
`timescale 1ns/10ps
`default_nettype none
module ugm_general_asserts (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              sessionValid,
  input wire logic              se0Line,
  input wire ugm_pkg::ugm_pad_t pad,
  input wire logic              vbusIrq,
  input wire logic [6:0]        epEnable,
  input wire logic [6:0]        epResetPulse,
  input wire logic              cpuReset
);
  logic       wrQ;
  logic [7:0] adQ;
  logic [7:0] wdQ;
  logic [9:0] se0Cnt;

  ////////////////////////////////
  // writes seen one cycle late, when their effect shows
  always_ff @(posedge clk)
  begin
    wrQ <= !rst && psel && penable && pwrite;
    adQ <= paddr;
    wdQ <= pwdata[7:0];
    if (rst || !se0Line || !pad.coreClkEn)
      se0Cnt <= 10'h000;
    else if (se0Cnt != 10'h3FF)
      se0Cnt <= se0Cnt + 10'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////
  property p_regen;
    wrQ && adQ == 8'h00 |-> pad.padRegEn == wdQ[0];
  endproperty
  a_regen: assert property (p_regen)
    else $error("regulator enable");
  property p_vpad;
    wrQ && adQ == 8'h04 |-> pad.vpadEn == wdQ[4];
  endproperty
  a_vpad: assert property (p_vpad)
    else $error("voltage pad enable");
  property p_off;
    wrQ && adQ == 8'h04 && !wdQ[7] |->
      (!pad.xcvrEn && !pad.coreClkEn && !pad.pullupOn)
      ##1 (epEnable == 7'h00);
  endproperty
  a_off: assert property (p_off)
    else $error("disable not a reset");
  property p_frz;
    wrQ && adQ == 8'h04 && wdQ[7] |-> pad.coreClkEn == !wdQ[5];
  endproperty
  a_frz: assert property (p_frz)
    else $error("clock gate");
  property p_eprst;
    epResetPulse != 7'h00 |->
      wrQ && adQ == 8'h20 && epResetPulse == wdQ[6:0]
      && epEnable == $past(epEnable);
  endproperty
  a_eprst: assert property (p_eprst)
    else $error("endpoint reset pulse");
  // vbus status lags the input by one flop
  property p_pullup;
    pad.pullupOn |-> $past(sessionValid) && pad.xcvrEn;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up without voltage");
  property p_busrst;
    se0Cnt == 10'h271 |-> ##[0:4] epEnable[6:1] == 6'h00;
  endproperty
  a_busrst: assert property (p_busrst)
    else $error("bus reset");
  property p_cpurst;
    cpuReset |-> pad.xcvrEn && epEnable[6:1] == 6'h00;
  endproperty
  a_cpurst: assert property (p_cpurst)
    else $error("cpu reset");
  property p_sticky;
    $past(vbusIrq) && !wrQ |-> vbusIrq;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("voltage flag dropped");
endmodule : ugm_general_asserts
`default_nettype wire

// file: dv/ugm_host_model.sv
// host side stand-in: bus voltage and line events
`timescale 1ns/10ps
`default_nettype none
module ugm_host_model (
  input  wire logic clk,
  input  wire logic plug,
  input  wire logic busRst,
  input  wire logic wake,
  input  wire logic idle,
  output logic      sessionValid,
  output logic      se0Line,
  output logic      lineActivity,
  output logic      suspendDet
);
  logic wakeQ;
  logic idleQ;

  initial
  begin
    {sessionValid, se0Line, lineActivity, suspendDet, wakeQ, idleQ} = '0;
  end

  ////////////////////////////////
  always @(posedge clk)
  begin
    sessionValid <= plug;
    // se0 held as long as asked; none unplugged
    se0Line <= busRst && plug;
    lineActivity <= wake && !wakeQ;
    suspendDet <= idle && !idleQ;
    wakeQ <= wake;
    idleQ <= idle;
  end
endmodule : ugm_host_model
`default_nettype wire

// file: dv/tb_top.sv
// bench for the usb general control and endpoint memory block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err, r0;
  logic        plug, busRst, wake, idle, cpuSeen, vbusIrq, cpuReset;
  logic        sessionValid, se0Line, lineActivity, suspendDet;
  logic [7:0]  paddr, rd, d;
  logic [31:0] pwdata, prdata;
  logic [6:0]  epEnable, epResetPulse, bankFlush, toggleReset;
  ugm_pkg::ugm_pad_t pad;
  int          mismatches, testsRun, cyc;
  int          bas[7], ln[7], al[7], szA[7], bkA[7], enA[7];
  logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [7:0]  re[6] = '{8'h00, 8'h20, 8'h02, 8'h00, 8'h01, 8'h00};

  ugm_general dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sessionValid, .se0Line, .lineActivity,
    .suspendDet, .pad, .vbusIrq, .epEnable, .epResetPulse, .bankFlush,
    .toggleReset, .cpuReset);
  ugm_host_model host (.clk, .plug, .busRst, .wake, .idle, .sessionValid,
    .se0Line, .lineActivity, .suspendDet);

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // a hang ends the run as a failure
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cpuReset === 1'b1) cpuSeen <= 1'b1;
    if (cyc == 5000)
    begin
      mismatches++;
      final_report();
    end
  end

  ////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    testsRun++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one idle cycle between transfers, so no signal is driven twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, v};
    @(posedge clk);
    penable <= 1'b1;
    // pready ends this wait; if it never comes, only the bench timeout does
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk($sformatf("register %h", a), e, rd);
  endtask : rdc

  task automatic pc(input logic [5:0] e);
    #1;
    chk("pad", {2'h0, e | {4'h0, r0, 1'b0}}, {2'h0, pad});
  endtask : pc

  task automatic epv(input int k);
    int ok;
    ok = al[k] != 0 && szA[k] <= (k == 1 ? 5 : 3);
    apb(1'b1, 8'h18, 8'(k));
    rdc(8'h1C, 8'(ok * 128 + bkA[k] * 32 + szA[k] * 4 + al[k] * 2 + enA[k]));
    rdc(8'h24, 8'(bas[k]));
  endtask : epv

  // memory model: allocate inserts, free slides only the next one
  task automatic epw(input int k, input int en, input int a);
    if (a != 0 && al[k] == 0)
    begin
      ln[k] = (1 << szA[k]) * (bkA[k] + 1);
      bas[k] = (k == 0) ? 0 : bas[k-1] + ln[k-1];
      if (k < 6) bas[k+1] = bas[k] + ln[k];
    end
    else if (a == 0 && al[k] != 0 && k < 6) bas[k+1] = bas[k];
    al[k] = a;
    enA[k] = en;
    apb(1'b1, 8'h18, 8'(k));
    apb(1'b1, 8'h1C, 8'(bkA[k] * 32 + szA[k] * 4 + a * 2 + en));
    epv(k);
  endtask : epw

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  ////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, plug, busRst, wake, idle, cpuSeen, r0} = '0;
    rst = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    void'($urandom(32'h08CF));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    pc(6'h20);
    foreach (ra[i]) rdc(ra[i], re[i]);
    apb(1'b0, 8'h28, 8'h00);
    chk("slave error", 8'h01, 8'(err));
    r0 = 1'($urandom);
    apb(1'b1, 8'h00, {7'h00, r0});
    pc(6'h20);
    apb(1'b1, 8'h04, 8'h31);
    pc(6'h21);
    plug <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(8'h08, 8'h03);
    rdc(8'h0C, 8'h01);
    chk("irq", 8'h01, 8'(vbusIrq));
    apb(1'b1, 8'h0C, 8'h00);
    pc(6'h21);
    chk("irq", 8'h00, 8'(vbusIrq));
    apb(1'b1, 8'h04, 8'h91);
    pc(6'h2D);
    apb(1'b1, 8'h10, 8'h02);
    pc(6'h1D);
    plug <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("pull-up", 8'h00, 8'(pad.pullupOn));
    chk("irq", 8'h01, 8'(vbusIrq));
    plug <= 1'b1;
    apb(1'b1, 8'h0C, 8'h00);
    pc(6'h1D);
    for (int k = 0; k < 6; k++)
    begin
      szA[k] = $urandom % (k == 1 ? 6 : 4);
      bkA[k] = (k == 0) ? 0 : $urandom % 2;
      epw(k, 1, 1);
    end
    epw(3, 0, 1);
    epv(4);
    epw(3, 0, 0);
    epv(4);
    epv(5);
    szA[3] = 3;
    bkA[3] = 1;
    epw(3, 1, 1);
    epv(4);
    epv(5);
    epw(2, 0, 1);
    epw(2, 1, 1);
    epv(3);
    d = 8'($urandom % 128);
    apb(1'b1, 8'h20, d);
    #1;
    chk("endpoint reset", d, {1'b0, epResetPulse});
    chk("endpoint enable", 8'h3F, {1'b0, epEnable});
    apb(1'b1, 8'h1C, 8'h6F);
    #1;
    chk("toggle reset", 8'h08, {1'b0, toggleReset});
    busRst <= 1'b1;
    repeat (700) @(posedge clk);
    busRst <= 1'b0;
    for (int k = 1; k < 7; k++) enA[k] = 0;
    repeat (4) @(posedge clk);
    pc(6'h1D);
    chk("endpoint enable", 8'h01, {1'b0, epEnable});
    chk("cpu reset", 8'h01, 8'(cpuSeen));
    epv(0);
    idle <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("pad idle", 8'h01, 8'(pad.padIdle));
    rdc(8'h14, 8'h01);
    wake <= 1'b1;
    repeat (3) @(posedge clk);
    pc(6'h1D);
    rdc(8'h14, 8'h02);
    apb(1'b1, 8'h10, 8'h01);
    pc(6'h2D);
    apb(1'b1, 8'h04, 8'h10);
    pc(6'h21);
    // the device part is reset one edge after the disable
    @(posedge clk);
    #1;
    chk("flush", 8'h7F, {1'b0, bankFlush});
    chk("endpoint enable", 8'h00, {1'b0, epEnable});
    rdc(8'h10, 8'h01);
    final_report();
  end
endmodule : tb_top

bind ugm_general ugm_general_asserts chk_i (.clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .sessionValid, .se0Line, .pad, .vbusIrq,
  .epEnable, .epResetPulse, .cpuReset);
`default_nettype wire
